// File: hw/mmap_defines.svh
// Purpose: constants of the memory map and eeprom control block
// Assumes: included by its bare name
// Notes:   register indices are word indices; byte address is index * 4
`ifndef MMAP_DEFINES_SVH
`define MMAP_DEFINES_SVH
// ****************************************************************
// register indices and reset values
// ****************************************************************
`define MMAP_IDX_PROG    14'h103b
`define MMAP_IDX_REMAP   14'h103d
`define MMAP_IDX_PUMP    14'h1039
`define MMAP_IDX_STAT    14'h1040
`define MMAP_REMAP_RST   8'h01
`define MMAP_PROG_RST    8'h00
`define MMAP_PUMP_RST    8'h00
`define MMAP_INIT_WINDOW 7'h40
// ****************************************************************
// control register fields
// ****************************************************************
`define MMAP_B_HV        0
`define MMAP_B_LAT       1
`define MMAP_B_ERASE     2
`define MMAP_B_ROW       3
`define MMAP_B_BYTE      4
`define MMAP_B_ZERO      5
// ****************************************************************
// address map
// ****************************************************************
`define MMAP_REG_LOW0    6'h00
`define MMAP_RAM_LOW0    4'h0
`define MMAP_EEP_BASE    16'hb600
`define MMAP_EEP_TOP     16'hb7ff
`define MMAP_BOOT_BASE   16'hbf40
`define MMAP_BOOT_TOP    16'hbfff
`define MMAP_ROM_BASE    16'he000
`define MMAP_ERASED      8'hff
`define MMAP_UNDRIVEN    8'hff
`define MMAP_WB_UNMAPPED 32'h0000_0000
`endif

// File: hw/mmap_eectl.sv
// Purpose: memory map decode, remap register and eeprom program control
// Assumes: classic wishbone slave for registers, cpu bus on the same clock
// Notes:   eeprom array held here; ram, rom and peripherals live outside
//
// Added by the designer: register access over Wishbone.
`default_nettype none
`include "mmap_defines.svh"
module mmap_eectl
  import mmap_pkg::*;
#(
  parameter int EEP_WORDS = 512,
  parameter int ROW_BYTES = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone register port
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // cpu core bus
  input  wire logic        cpu_valid_i,
  input  wire logic        cpu_we_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [7:0]  cpu_wdata_i,
  input  wire logic [7:0]  ext_rdata_i,
  output logic [5:0]       cpu_sel_o,
  output logic [7:0]       cpu_rdata_o,
  // option cells and mode pins
  input  wire logic        rom_enable_cell_i,
  input  wire logic        eeprom_enable_cell_i,
  input  wire logic        mode_single_chip_i,
  input  wire logic        mode_bootstrap_i,
  // charge pump
  output logic             high_voltage_on_o,
  output logic             pump_clock_source_sel_o
);
  localparam int EA = $clog2(EEP_WORDS);
  localparam int RA = $clog2(ROW_BYTES);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_s3_r;
  logic [3:0] pin_f_r;
  // no reset on the chain; reset must be held long enough to fill it
  always_ff @(posedge clk_i) begin
    pin_s1_r <= {mode_bootstrap_i, mode_single_chip_i, eeprom_enable_cell_i, rom_enable_cell_i};
    pin_s2_r <= pin_s1_r;
    pin_s3_r <= pin_s2_r;
  end
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (pin_s2_r[i] == pin_s3_r[i]) begin
        pin_f_r[i] <= pin_s3_r[i];
      end
    end
  end

  // bootstrap mode is caught at the release of reset and then held
  logic rst_seen_r;
  logic boot_en_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_seen_r <= 1'b1;
    end else if (rst_seen_r) begin
      rst_seen_r <= 1'b0;
      boot_en_r  <= pin_f_r[3];
    end
  end

  logic rom_en;
  logic eep_en;
  assign rom_en = pin_f_r[0] | pin_f_r[2];
  assign eep_en = pin_f_r[1];

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  remap_r;
  logic [7:0]  prog_r;
  logic [7:0]  pump_r;
  logic        remap_locked_r;
  logic [6:0]  win_cnt_r;
  logic        wb_ack_r;
  logic [31:0] wb_dat_r;
  logic [13:0] wb_idx;
  logic        wb_req;
  logic        wb_wr;
  logic [7:0]  prog_nxt;

  assign wb_idx   = wb_adr_i[15:2];
  assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_r;
  assign wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r <= 1'b0;
    end else begin
      wb_ack_r <= wb_req;
    end
  end

  // init window counter: saturates at the window length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt_r <= 7'h00;
    end else if (win_cnt_r != `MMAP_INIT_WINDOW) begin
      win_cnt_r <= win_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remap_r        <= `MMAP_REMAP_RST;
      remap_locked_r <= 1'b0;
    end else begin
      if (wb_wr && wb_idx == `MMAP_IDX_REMAP && !remap_locked_r
          && win_cnt_r != `MMAP_INIT_WINDOW) begin
        remap_r        <= wb_dat_i[7:0];
        remap_locked_r <= 1'b1;
      end else if (win_cnt_r == `MMAP_INIT_WINDOW) begin
        remap_locked_r <= 1'b1;
      end
    end
  end

  // latch and voltage rising together in one write are both dropped
  always_comb begin
    prog_nxt = wb_dat_i[7:0];
    prog_nxt[`MMAP_B_ZERO] = 1'b0;
    if (wb_dat_i[`MMAP_B_LAT] && wb_dat_i[`MMAP_B_HV]
        && !prog_r[`MMAP_B_LAT] && !prog_r[`MMAP_B_HV]) begin
      prog_nxt[`MMAP_B_LAT] = 1'b0;
      prog_nxt[`MMAP_B_HV]  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_r <= `MMAP_PROG_RST;
    end else if (wb_wr && wb_idx == `MMAP_IDX_PROG) begin
      prog_r <= prog_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pump_r <= `MMAP_PUMP_RST;
    end else if (wb_wr && wb_idx == `MMAP_IDX_PUMP) begin
      pump_r <= wb_dat_i[7:0];
    end
  end

  logic hv_on;
  logic latched;
  assign latched                 = prog_r[`MMAP_B_LAT];
  assign hv_on                   = prog_r[`MMAP_B_HV] & latched;
  assign high_voltage_on_o       = hv_on;
  assign pump_clock_source_sel_o = pump_r[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_r <= `MMAP_WB_UNMAPPED;
    end else if (wb_req) begin
      case (wb_idx)
        `MMAP_IDX_REMAP: wb_dat_r <= {24'h000000, remap_r};
        `MMAP_IDX_PROG:  wb_dat_r <= {24'h000000, prog_r};
        `MMAP_IDX_PUMP:  wb_dat_r <= {24'h000000, pump_r};
        `MMAP_IDX_STAT:  wb_dat_r <= {26'h0000000, hv_on, remap_locked_r, boot_en_r, eep_en, rom_en, latched};
        default:         wb_dat_r <= `MMAP_WB_UNMAPPED;
      endcase
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic      hit_reg;
  logic      hit_ram;
  logic      hit_boot;
  logic      hit_eep;
  logic      hit_rom;
  mmap_sel_e sel;
  assign hit_reg  = cpu_addr_i[15:12] == remap_r[3:0] && cpu_addr_i[11:6] == `MMAP_REG_LOW0;
  assign hit_ram  = cpu_addr_i[15:12] == remap_r[7:4] && cpu_addr_i[11:8] == `MMAP_RAM_LOW0;
  assign hit_boot = boot_en_r && cpu_addr_i >= `MMAP_BOOT_BASE && cpu_addr_i <= `MMAP_BOOT_TOP;
  assign hit_eep  = eep_en && cpu_addr_i >= `MMAP_EEP_BASE && cpu_addr_i <= `MMAP_EEP_TOP;
  assign hit_rom  = rom_en && cpu_addr_i >= `MMAP_ROM_BASE;

  // fixed priority keeps exactly one select even when pages collide
  always_comb begin
    if (hit_reg) begin
      sel = MMAP_SEL_REG;
    end else if (hit_ram) begin
      sel = MMAP_SEL_RAM;
    end else if (hit_boot) begin
      sel = MMAP_SEL_BOOT;
    end else if (hit_eep) begin
      sel = MMAP_SEL_EEP;
    end else if (hit_rom) begin
      sel = MMAP_SEL_ROM;
    end else begin
      sel = MMAP_SEL_EXT;
    end
  end
  assign cpu_sel_o = cpu_valid_i ? sel : 6'h00;

  // ****************************************************************
  // eeprom array and program / erase
  // ****************************************************************
  logic [7:0]    eep_mem [EEP_WORDS];
  logic [EA-1:0] lat_addr_r;
  logic [7:0]    lat_data_r;
  logic          hv_d_r;
  logic          eep_wr;
  logic          hv_start;
  assign eep_wr   = cpu_valid_i & cpu_we_i & (sel == MMAP_SEL_EEP);
  assign hv_start = hv_on & ~hv_d_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_addr_r <= '0;
      lat_data_r <= `MMAP_ERASED;
    end else if (eep_wr && latched && !hv_on) begin
      lat_addr_r <= cpu_addr_i[EA-1:0];
      lat_data_r <= cpu_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_d_r <= 1'b0;
    end else begin
      hv_d_r <= hv_on;
    end
  end

  // whole operation is applied at the voltage turn-on edge; the hold time
  // is software's to keep and is not timed here
  always_ff @(posedge clk_i) begin
    if (!rst_i && hv_start) begin
      if (!prog_r[`MMAP_B_ERASE]) begin
        eep_mem[lat_addr_r] <= eep_mem[lat_addr_r] & lat_data_r;
      end else if (prog_r[`MMAP_B_BYTE]) begin
        eep_mem[lat_addr_r] <= `MMAP_ERASED;
      end else if (prog_r[`MMAP_B_ROW]) begin
        for (int i = 0; i < ROW_BYTES; i++) begin
          eep_mem[{lat_addr_r[EA-1:RA], RA'(i)}] <= `MMAP_ERASED;
        end
      end else begin
        for (int i = 0; i < EEP_WORDS; i++) begin
          eep_mem[i] <= `MMAP_ERASED;
        end
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_rdata_o <= `MMAP_UNDRIVEN;
    end else if (cpu_valid_i && !cpu_we_i) begin
      case (sel)
        MMAP_SEL_EEP: cpu_rdata_o <= latched ? `MMAP_UNDRIVEN : eep_mem[cpu_addr_i[EA-1:0]];
        MMAP_SEL_EXT: cpu_rdata_o <= ext_rdata_i;
        default:      cpu_rdata_o <= `MMAP_UNDRIVEN;
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  remap_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    remap_locked_r |=> $stable(remap_r)) else $error("remap changed after lock");
  window_close_a: assert property (@(posedge clk_i) disable iff (rst_i)
    win_cnt_r == `MMAP_INIT_WINDOW |=> remap_locked_r) else $error("remap open past window");
  reset_vals_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> remap_r == `MMAP_REMAP_RST && prog_r == `MMAP_PROG_RST) else $error("bad reset value");
  reg_prio_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_valid_i && hit_reg |-> cpu_sel_o == MMAP_SEL_REG) else $error("register block lost priority");
  ram_over_rom_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_valid_i && hit_ram && !hit_reg |-> cpu_sel_o == MMAP_SEL_RAM) else $error("ram lost to lower resource");
  one_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_valid_i |-> $onehot(cpu_sel_o)) else $error("select not one-hot");
  bit_five_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !prog_r[`MMAP_B_ZERO]) else $error("control bit 5 set");
  both_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_wr && wb_idx == `MMAP_IDX_PROG && wb_dat_i[1:0] == 2'b11 && prog_r[1:0] == 2'b00
    |=> prog_r[1:0] == 2'b00) else $error("latch and voltage set together");
  hv_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hv_on && eep_wr |=> $stable(lat_addr_r) && $stable(lat_data_r)) else $error("write disturbed operation");
  eep_read_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_valid_i && !cpu_we_i && sel == MMAP_SEL_EEP && latched |=> cpu_rdata_o == `MMAP_UNDRIVEN)
    else $error("eeprom drove bus while latched");
  rom_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_sel_o == MMAP_SEL_ROM |-> rom_en && cpu_addr_i >= `MMAP_ROM_BASE) else $error("rom selected while off");
endmodule : mmap_eectl
`default_nettype wire

// File: hw/mmap_pkg.sv
// Purpose: types of the memory map and eeprom control block
// Assumes: nothing
// Notes:   one-hot select codes, one per resource
`default_nettype none
package mmap_pkg;
  typedef enum logic [5:0] {
    MMAP_SEL_REG  = 6'h01,
    MMAP_SEL_RAM  = 6'h02,
    MMAP_SEL_BOOT = 6'h04,
    MMAP_SEL_EEP  = 6'h08,
    MMAP_SEL_ROM  = 6'h10,
    MMAP_SEL_EXT  = 6'h20
  } mmap_sel_e;
endpackage : mmap_pkg
`default_nettype wire

// File: verification/mmap_ext_mem.sv
// Purpose: external memory and i/o device on the cpu bus
// Assumes: device decodes every address and answers at once
// Notes:   an idle bus floats, so it shows a changing pattern
`default_nettype none
module mmap_ext_mem
(
  input  wire logic        clk_i,
  input  wire logic        valid_i,
  input  wire logic [15:0] addr_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] float_r = 8'h00;
  // *********
  // data path
  // *********
  // a stale value on a floating bus could hide a wrong select
  always_ff @(posedge clk_i) begin
    float_r <= float_r + 8'h01;
  end
  // drives on every access, also where an internal resource wins
  assign rdata_o = valid_i ? (addr_i[7:0] ^ 8'h5a) : float_r;
endmodule : mmap_ext_mem
`default_nettype wire

// File: verification/tb.sv
// Purpose: self-checking bench for mmap_eectl
// Assumes: 250 MHz clock, synchronous reset held 5 edges
// Notes:   eeprom contents unknown until the first bulk erase
`default_nettype none
module tb
  import mmap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] A_PROG  = 16'h40ec;
  localparam logic [15:0] A_REMAP = 16'h40f4;
  localparam logic [15:0] A_PUMP  = 16'h40e4;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        wcyc   = 1'b0;
  logic        wwe    = 1'b0;
  logic [15:0] wadr   = 16'h0000;
  logic [31:0] wdat   = 32'h0000_0000;
  logic        cval   = 1'b0;
  logic        cwe    = 1'b0;
  logic [15:0] cadr   = 16'h0000;
  logic [7:0]  cwd    = 8'h00;
  logic        rom_c  = 1'b1;
  logic        eep_c  = 1'b1;
  logic        single = 1'b0;
  logic        boot   = 1'b0;
  logic [31:0] wdo, wq;
  logic        wack, hv, pump;
  logic [7:0]  erd, crd, rd_s;
  logic [5:0]  pump_clock_source_sel, sel_s;
  int          n_mismatch = 0;
  int          compares   = 0;

  always #2 clk_i = ~clk_i;

  mmap_eectl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wcyc), .wb_stb_i(wcyc),
    .wb_we_i(wwe), .wb_adr_i(wadr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wdo),
    .wb_ack_o(wack), .cpu_valid_i(cval), .cpu_we_i(cwe), .cpu_addr_i(cadr),
    .cpu_wdata_i(cwd), .ext_rdata_i(erd), .cpu_sel_o(pump_clock_source_sel), .cpu_rdata_o(crd),
    .rom_enable_cell_i(rom_c), .eeprom_enable_cell_i(eep_c), .mode_single_chip_i(single),
    .mode_bootstrap_i(boot), .high_voltage_on_o(hv), .pump_clock_source_sel_o(pump));
  mmap_ext_mem u_ext (.clk_i(clk_i), .valid_i(cval), .addr_i(cadr), .rdata_o(erd));

  // *************
  // bus tasks
  // *************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wcyc <= 1'b1;
    wwe  <= w;
    wadr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (wack !== 1'b1);
    wq = wdo;
    wcyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk("register", {24'h0, e}, wq);
  endtask : rreg
  // select settles in the cycle, read data one edge later
  task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cval <= 1'b1;
    cwe  <= w;
    cadr <= a;
    cwd  <= d;
    @(posedge clk_i);
    #1;
    sel_s = pump_clock_source_sel;
    rd_s  = crd;
    @(posedge clk_i);
    cval <= 1'b0;
  endtask : cpu
  task automatic look(input logic [15:0] a, input logic [5:0] e);
    cpu(1'b0, a, 8'h00);
    chk("select", {26'h0, e}, {26'h0, sel_s});
  endtask : look
  task automatic peek(input logic [15:0] a, input logic [7:0] e);
    cpu(1'b0, a, 8'h00);
    chk("rdata", {24'h0, e}, {24'h0, rd_s});
  endtask : peek
  // latch, write, raise voltage, stray write, back to read
  task automatic eop(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    wb(1'b1, A_PROG, c);
    cpu(1'b1, a, d);
    wb(1'b1, A_PROG, c | 8'h01);
    // voltage hold is scaled down to a few cycles to keep runs short
    repeat (4) @(posedge clk_i);
    chk("hv", 32'h1, {31'h0, hv});
    cpu(1'b1, 16'hb7f0, 8'h00);
    wb(1'b1, A_PROG, 8'h00);
  endtask : eop

  // *************
  // scenarios
  // *************
  task automatic t_remap();
    rreg(A_REMAP, 8'h01);
    wb(1'b1, A_REMAP, 8'hee);
    wb(1'b1, A_REMAP, 8'h01);
    rreg(A_REMAP, 8'hee);
    rreg(A_PROG, 8'h00);
    rreg(16'h0010, 8'h00);
    look(16'he010, MMAP_SEL_REG);
    look(16'he050, MMAP_SEL_RAM);
    look(16'hf000, MMAP_SEL_ROM);
    look(16'h0000, MMAP_SEL_EXT);
    look(16'hbf40, MMAP_SEL_EXT);
    peek(16'he035, 8'hff);
    peek(16'h8000, 8'h5a);
  endtask : t_remap
  task automatic t_eep();
    eop(8'h06, 16'hb600, 8'h00);
    peek(16'hb600, 8'hff);
    peek(16'hb7ff, 8'hff);
    eop(8'h02, 16'hb612, 8'h55);
    peek(16'hb612, 8'h55);
    eop(8'h02, 16'hb612, 8'h0f);
    peek(16'hb612, 8'h05);
    eop(8'h02, 16'hb620, 8'h12);
    eop(8'h02, 16'hb621, 8'h34);
    wb(1'b1, A_PROG, 8'h02);
    peek(16'hb621, 8'hff);
    wb(1'b1, A_PROG, 8'h00);
    cpu(1'b1, 16'hb621, 8'h00);
    peek(16'hb621, 8'h34);
    eop(8'h0e, 16'hb61a, 8'h00);
    peek(16'hb612, 8'hff);
    peek(16'hb621, 8'h34);
    eop(8'h1e, 16'hb620, 8'h00);
    peek(16'hb620, 8'hff);
    peek(16'hb621, 8'h34);
    peek(16'hb7f0, 8'hff);
    wb(1'b1, A_PROG, 8'h23);
    rreg(A_PROG, 8'h00);
    chk("hv", 32'h0, {31'h0, hv});
    wb(1'b1, A_PROG, 8'h24);
    rreg(A_PROG, 8'h04);
    wb(1'b1, A_PROG, 8'h00);
  endtask : t_eep
  // cells pass a sync filter, so allow it a few edges
  task automatic t_cells();
    look(16'hb600, MMAP_SEL_EEP);
    @(posedge clk_i);
    rom_c <= 1'b0;
    eep_c <= 1'b0;
    repeat (6) @(posedge clk_i);
    look(16'hf000, MMAP_SEL_EXT);
    look(16'hb600, MMAP_SEL_EXT);
    single <= 1'b1;
    repeat (6) @(posedge clk_i);
    look(16'hf000, MMAP_SEL_ROM);
    wb(1'b1, A_PUMP, 8'h01);
    chk("pump", 32'h1, {31'h0, pump});
  endtask : t_cells
  task automatic t_boot();
    @(posedge clk_i);
    boot   <= 1'b1;
    single <= 1'b0;
    rst_i  <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    look(16'h00ff, MMAP_SEL_RAM);
    look(16'h0100, MMAP_SEL_EXT);
    look(16'h103f, MMAP_SEL_REG);
    look(16'h1040, MMAP_SEL_EXT);
    look(16'hbf40, MMAP_SEL_BOOT);
    look(16'hbfff, MMAP_SEL_BOOT);
    look(16'he000, MMAP_SEL_EXT);
    repeat (64) @(posedge clk_i);
    wb(1'b1, A_REMAP, 8'h23);
    rreg(A_REMAP, 8'h01);
  endtask : t_boot

  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_remap();
    t_eep();
    t_cells();
    t_boot();
    give_verdict();
  end
  // runs take under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
